// ===== sfc_subcarrier_ctrl.sv
// Top of the SD subcarrier frequency control block.
// Assumes core_clk is the pixel clock and register accesses are synchronous.
`timescale 1ns/1ns
module sfc_subcarrier_ctrl
  import sfc_pkg::*;
#(
  parameter int PHASE_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire sfc_reg_req_type reg_req,
  input wire logic ntsc_sel,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [31:0] active_freq_word,
  output logic [PHASE_W-1:0] subcarrier_phase,
  output logic square_pixel_en,
  output logic noninterlaced_en,
  output sfc_geom_type active_geom
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [3:0][7:0] shadow;
    logic [31:0] word;
    logic [7:0] mode82;
    logic [7:0] mode88;
    logic [7:0] rdata;
    logic rvalid;
    sfc_geom_type geom;
  } sfc_state_type;

  sfc_state_type st;
  sfc_state_type next_st;

  // Map a subaddress to frequency byte index
  function automatic logic [2:0] byte_sel(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h4;
    if (a == SFC_ADDR_BYTE0) r = 3'h0;
    if (a == SFC_ADDR_BYTE1) r = 3'h1;
    if (a == SFC_ADDR_BYTE2) r = 3'h2;
    if (a == SFC_ADDR_BYTE3) r = 3'h3;
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register writes, reads and word commit
  always_comb begin
    logic [2:0] sel;
    logic [31:0] assembled;
    assembled = SFC_ZERO32;
    sel = byte_sel(reg_req.addr);
    next_st = st;
    next_st.rvalid = 1'b0;
    if (reg_req.wr) begin
      if (sel != 3'h4) begin
        next_st.shadow[sel[1:0]] = reg_req.wdata;
      end
      if (reg_req.addr == SFC_ADDR_MODE82) begin
        next_st.mode82 = reg_req.wdata;
      end
      if (reg_req.addr == SFC_ADDR_MODE88) begin
        next_st.mode88 = reg_req.wdata;
      end
      // Byte 3 commits all four bytes at once
      if (sel == 3'h3) begin
        assembled = {reg_req.wdata, st.shadow[2], st.shadow[1], st.shadow[0]};
        next_st.word = assembled;
      end
    end
    if (reg_req.rd) begin
      next_st.rvalid = 1'b1;
      if (sel != 3'h4) begin
        next_st.rdata = st.shadow[sel[1:0]];
      end else if (reg_req.addr == SFC_ADDR_MODE82) begin
        next_st.rdata = st.mode82;
      end else if (reg_req.addr == SFC_ADDR_MODE88) begin
        next_st.rdata = st.mode88;
      end else begin
        next_st.rdata = SFC_BYTE_RESET;
      end
    end
    // Active picture geometry from mode bits
    next_st.geom.progressive = st.mode88[SFC_BIT_NONINT];
    if (st.mode82[SFC_BIT_SQUARE]) begin
      next_st.geom.width = ntsc_sel ? SFC_W_SQ_NTSC : SFC_W_SQ_PAL;
    end else begin
      next_st.geom.width = ntsc_sel ? SFC_W_NTSC : SFC_W_PAL;
    end
    if (st.mode88[SFC_BIT_NONINT]) begin
      next_st.geom.height = ntsc_sel ? SFC_H_PROG_NTSC : SFC_H_PROG_PAL;
    end else begin
      next_st.geom.height = ntsc_sel ? SFC_H_NTSC : SFC_H_PAL;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st.shadow <= {SFC_WORD_RESET[31:24], SFC_WORD_RESET[23:16], SFC_WORD_RESET[15:8], SFC_WORD_RESET[7:0]};
      st.word <= SFC_WORD_RESET;
      st.mode82 <= SFC_BYTE_RESET;
      st.mode88 <= SFC_BYTE_RESET;
      st.rdata <= SFC_BYTE_RESET;
      st.rvalid <= 1'b0;
      st.geom <= '0;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Subcarrier phase generation
  sfc_phase_acc #(
    .PHASE_W(PHASE_W)
  ) u_acc (
    .core_clk(core_clk),
    .resetn(resetn),
    .freq_word(st.word),
    .phase(subcarrier_phase)
  );

  // Outputs
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign active_freq_word = st.word;
  assign square_pixel_en = st.mode82[SFC_BIT_SQUARE];
  assign noninterlaced_en = st.mode88[SFC_BIT_NONINT];
  assign active_geom = st.geom;

endmodule

// ===== sfc_pkg.sv
// Constants and types for the SD colour subcarrier frequency block.
// Assumes a byte-wide register port with subaddress, write and read strobes.
// Operation
// - Four byte registers form 32-bit frequency word
// - Byte 0 least significant, byte 3 most
// - New word applied only after byte 3
// - Noninterlaced bit accepts 240p or 288p input
// - Noninterlaced: 27 MHz clock, codes or syncs
// - Noninterlaced keeps all normal SD features
// - Square-pixel bit; 24.5454 or 29.5 MHz clock
// - Square-pixel active picture 640x480 or 768x576
package sfc_pkg;

  localparam logic [7:0] SFC_ADDR_BYTE0 = 8'h8c;
  localparam logic [7:0] SFC_ADDR_BYTE1 = 8'h8d;
  localparam logic [7:0] SFC_ADDR_BYTE2 = 8'h8e;
  localparam logic [7:0] SFC_ADDR_BYTE3 = 8'h8f;
  localparam logic [7:0] SFC_ADDR_MODE82 = 8'h82;
  localparam logic [7:0] SFC_ADDR_MODE88 = 8'h88;
  localparam int SFC_BIT_SQUARE = 4;
  localparam int SFC_BIT_NONINT = 1;
  localparam logic [31:0] SFC_WORD_RESET = 32'h21f0_7c1f;
  localparam logic [7:0] SFC_BYTE_RESET = 8'h00;
  localparam logic [31:0] SFC_ZERO32 = 32'h0000_0000;

  // Active picture sizes per mode
  localparam logic [9:0] SFC_W_NTSC = 10'h2d0;
  localparam logic [9:0] SFC_H_NTSC = 10'h1e0;
  localparam logic [9:0] SFC_W_PAL = 10'h2d0;
  localparam logic [9:0] SFC_H_PAL = 10'h240;
  localparam logic [9:0] SFC_W_SQ_NTSC = 10'h280;
  localparam logic [9:0] SFC_W_SQ_PAL = 10'h300;
  localparam logic [9:0] SFC_H_PROG_NTSC = 10'h0f0;
  localparam logic [9:0] SFC_H_PROG_PAL = 10'h120;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfc_reg_req_type;

  typedef struct packed {
    logic [9:0] width;
    logic [9:0] height;
    logic progressive;
  } sfc_geom_type;

endpackage

// ===== sfc_phase_acc.sv
// Subcarrier phase accumulator.
// Assumes one increment per pixel clock cycle.
`timescale 1ns/1ns
module sfc_phase_acc
  import sfc_pkg::*;
#(
  parameter int PHASE_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] freq_word,
  output logic [PHASE_W-1:0] phase
);

  initial begin
    if (PHASE_W < 1 || PHASE_W > 32) begin
      $error("PHASE_W out of range");
    end
  end

  typedef struct packed {
    logic [31:0] acc;
  } sfc_acc_state_type;

  sfc_acc_state_type st;
  sfc_acc_state_type next_st;

  // Accumulate word each clock
  always_comb begin
    next_st = st;
    next_st.acc = st.acc + freq_word;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign phase = st.acc[31 -: PHASE_W];

endmodule

// ===== sfc_subcarrier_ctrl_chk.sv
// Assertion checker for the subcarrier control top.
// Assumes it is bound to sfc_subcarrier_ctrl and sees only its ports.
`timescale 1ns/1ns
module sfc_chk
  import sfc_pkg::*;
#(
  parameter int PHASE_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire sfc_reg_req_type reg_req,
  input wire logic ntsc_sel,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [31:0] active_freq_word,
  input wire logic [PHASE_W-1:0] subcarrier_phase,
  input wire logic square_pixel_en,
  input wire logic noninterlaced_en,
  input wire sfc_geom_type active_geom
);
  logic [31:0] acc;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_wr3; reg_req.wr && reg_req.addr == SFC_ADDR_BYTE3; endsequence
  sequence s_sq_ntsc; square_pixel_en && ntsc_sel ##1 square_pixel_en && ntsc_sel; endsequence
  // Reference accumulator
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc <= 32'h0000_0000;
    end else begin
      acc <= acc + active_freq_word;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_word_commit: assert property (s_wr3 |=> active_freq_word[31:24] == $past(reg_req.wdata))
    else $error("top byte not committed");
  a_word_hold: assert property (!(reg_req.wr && reg_req.addr == SFC_ADDR_BYTE3) |=> $stable(active_freq_word))
    else $error("word changed without top byte");
  a_phase_track: assert property (subcarrier_phase == acc[31 -: PHASE_W])
    else $error("phase off");
  a_read_pulse: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  a_top_readback: assert property (reg_req.rd && !reg_req.wr && reg_req.addr == SFC_ADDR_BYTE3
    |=> reg_rdata == active_freq_word[31:24])
    else $error("top byte readback off");
  a_square_bit: assert property (reg_req.wr && reg_req.addr == SFC_ADDR_MODE82
    |=> square_pixel_en == $past(reg_req.wdata[SFC_BIT_SQUARE]))
    else $error("square bit off");
  a_nonint_bit: assert property (reg_req.wr && reg_req.addr == SFC_ADDR_MODE88
    |=> noninterlaced_en == $past(reg_req.wdata[SFC_BIT_NONINT]))
    else $error("noninterlaced bit off");
  a_square_geom: assert property (s_sq_ntsc |-> active_geom.width == SFC_W_SQ_NTSC)
    else $error("square width off");
endmodule
bind sfc_subcarrier_ctrl sfc_chk #(.PHASE_W(PHASE_W)) u_sfc_chk (.core_clk(core_clk), .resetn(resetn),
  .reg_req(reg_req), .ntsc_sel(ntsc_sel), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .active_freq_word(active_freq_word), .subcarrier_phase(subcarrier_phase),
  .square_pixel_en(square_pixel_en), .noninterlaced_en(noninterlaced_en), .active_geom(active_geom));

// ===== sfc_subcarrier_ctrl_tb_top.sv
// Self-checking bench for the subcarrier control top.
// Assumes the bench alone drives the register port.
`timescale 1ns/1ns
module sfc_subcarrier_ctrl_tb_top
  import sfc_pkg::*;
;
  logic core_clk, resetn, ntsc_sel, reg_rvalid, square_pixel_en, noninterlaced_en;
  sfc_reg_req_type reg_req;
  logic [7:0] reg_rdata;
  logic [31:0] active_freq_word;
  logic [11:0] subcarrier_phase;
  sfc_geom_type active_geom;
  int num_errors = 0;
  int comparisons = 0;
  logic [7:0] pal[4] = '{8'hcb, 8'h8a, 8'h09, 8'h2a};
  logic [7:0] ntsc[4] = '{8'h1f, 8'h7c, 8'hf0, 8'h21};
  sfc_subcarrier_ctrl u_sfc_subcarrier_ctrl (.core_clk(core_clk), .resetn(resetn), .reg_req(reg_req),
    .ntsc_sel(ntsc_sel), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .active_freq_word(active_freq_word),
    .subcarrier_phase(subcarrier_phase), .square_pixel_en(square_pixel_en),
    .noninterlaced_en(noninterlaced_en), .active_geom(active_geom));
  // Clock
  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  // Compare and register access tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{a, d, 1'b1, 1'b0};
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_req = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge core_clk);
    reg_req = '0;
    chk(32'(reg_rvalid), 32'h0000_0001, "rvalid");
    chk(32'(reg_rdata), 32'(exp), "rdata");
    @(negedge core_clk);
  endtask
  task automatic idle(input int n);
    reg_req = '0;
    repeat (n) @(negedge core_clk);
  endtask
  // Program four bytes, word changes only at the top byte
  task automatic prog(input logic [7:0] b[4], input logic [31:0] old);
    for (int i = 0; i < 4; i++) begin
      wr(8'(SFC_ADDR_BYTE0 + i), b[i]);
      chk(active_freq_word, i < 3 ? old : {b[3], b[2], b[1], b[0]}, "word");
    end
    for (int i = 0; i < 4; i++) rd(8'(SFC_ADDR_BYTE0 + i), b[i]);
  endtask
  task automatic results();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    results();
  end
  // Main sequence
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    ntsc_sel = 1'b1;
    reg_req = '0;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    chk(active_freq_word, 32'h21f0_7c1f, "reset word");
    prog(pal, 32'h21f0_7c1f);
    prog(ntsc, 32'h2a09_8acb);
    wr(8'h90, 8'hff);
    rd(8'h90, 8'h00);
    chk(active_freq_word, 32'h21f0_7c1f, "word");
    wr(SFC_ADDR_MODE82, 8'h10);
    chk(32'(square_pixel_en), 32'h0000_0001, "square");
    idle(2);
    chk(active_geom, {SFC_W_SQ_NTSC, SFC_H_NTSC, 1'b0}, "geom");
    ntsc_sel = 1'b0;
    idle(2);
    chk(active_geom, {SFC_W_SQ_PAL, SFC_H_PAL, 1'b0}, "geom");
    prog(pal, 32'h21f0_7c1f);
    wr(SFC_ADDR_MODE82, 8'h00);
    chk(32'(square_pixel_en), 32'h0000_0000, "square");
    wr(SFC_ADDR_MODE88, 8'h02);
    chk(32'(noninterlaced_en), 32'h0000_0001, "nonint");
    idle(2);
    chk(active_geom, {SFC_W_PAL, SFC_H_PROG_PAL, 1'b1}, "geom");
    ntsc_sel = 1'b1;
    idle(2);
    chk(active_geom, {SFC_W_NTSC, SFC_H_PROG_NTSC, 1'b1}, "geom");
    results();
  end
endmodule
